// *** tcp_consts.vh ***
`ifndef TCP_CONSTS_VH
`define TCP_CONSTS_VH

// register indices; byte address is four times the index
`define TCP_IDX_T0_CNT_HI  12'hF00
`define TCP_IDX_T0_CNT_LO  12'hF01
`define TCP_IDX_T0_CMP_LO  12'hF05
`define TCP_IDX_T0_CTL0    12'hF06
`define TCP_IDX_T1_CNT_HI  12'hF08
`define TCP_IDX_T1_CNT_LO  12'hF09
`define TCP_IDX_T1_CMP_LO  12'hF0D
`define TCP_IDX_T1_CTL0    12'hF0E

// decode of index bits [13:4], [3] and [2:0]
`define TCP_IDX_PAGE       10'h0F0
`define TCP_SUB_CNT_HI     3'h0
`define TCP_SUB_CNT_LO     3'h1
`define TCP_SUB_RLD_HI     3'h2
`define TCP_SUB_RLD_LO     3'h3
`define TCP_SUB_CMP_HI     3'h4
`define TCP_SUB_CMP_LO     3'h5
`define TCP_SUB_CTL0       3'h6
`define TCP_SUB_CTL1       3'h7

// control zero fields
`define TCP_C0_MODE_MSB    7
`define TCP_C0_IRQ_HI      6
`define TCP_C0_IRQ_LO      5
`define TCP_C0_DB_HI       3
`define TCP_C0_DB_LO       1
`define TCP_C0_CAPST       0

// control one fields
`define TCP_C1_EN          7
`define TCP_C1_POL         6
`define TCP_C1_MODE_HI     2
`define TCP_C1_MODE_LO     0

// four-bit modes
`define TCP_MODE_CONT      4'h1
`define TCP_MODE_CAPT      4'h4
`define TCP_MODE_CAPCMP    4'h7
`define TCP_MODE_COMPCNT   4'h8

// event definition select
`define TCP_IRQ_CAPT_ONLY  2'h2
`define TCP_IRQ_RLD_ONLY   2'h3

// reset values
`define TCP_RST_CNT        16'h0001
`define TCP_RST_WORD       16'h0000
`define TCP_RST_BYTE       8'h00

`endif

// *** tcp_timer_regs.v ***
// Design decision made here: register access over APB.
`timescale 1ns/1ns
`include "tcp_consts.vh"
// Notes on behaviour
// - count is 16 bits, read as high byte and low byte
// - enabled: reading count high copies live low byte into holder
// - enabled: reading count low returns the holder
// - disabled: reading count low returns live low byte
// - count byte writes land next edge; counting resumes from result
// - reload high write goes to a holder only
// - reload low write loads holder and low byte together
// - compare value checked against count every clock while enabled, except in the capture modes
// - compare match toggles the output level
// - output level set by polarity bit in control one
// - capture modes store count into compare bytes
// - control zero bit 7 is mode msb over control one field
// - control zero two-bit field defines which events signal
// - control zero holds deadband delay for output transitions
// - status bit shows last event came from capture
// - two timers, each with own registers at own addresses
// - comparator counter: at reload, signal, count to 0x0001, go on
module tcp_timer_regs (
    input  wire        SYS_CLK,
    input  wire        RST_N,
    input  wire        PSEL,
    input  wire        PENABLE,
    input  wire        PWRITE,
    input  wire [15:0] PADDR,
    input  wire [31:0] PWDATA,
    output reg  [31:0] PRDATA,
    output reg         PREADY,
    output reg         PSLVERR,
    input  wire [1:0]  CAP_IN,
    input  wire        CMP_IN,
    output reg  [1:0]  PWM_OUT,
    output reg  [1:0]  TMR_EVT
);

////////////////////////////////////////////////////////////////////////////////

function [3:0] mode_of;
    input [7:0] c0;
    input [7:0] c1;
    begin
        mode_of = {c0[`TCP_C0_MODE_MSB], c1[`TCP_C1_MODE_HI:`TCP_C1_MODE_LO]};
    end
endfunction

// polarity picks rising (0) or falling (1) edge
function edge_of;
    input cur;
    input prev;
    input pol;
    begin
        edge_of = (cur ^ pol) & ~(prev ^ pol);
    end
endfunction

////////////////////////////////////////////////////////////////////////////////

reg  [15:0] cnt_q   [0:1];
reg  [15:0] cnt_d   [0:1];
reg  [15:0] rld_q   [0:1];
reg  [15:0] rld_d   [0:1];
reg  [15:0] cmp_q   [0:1];
reg  [15:0] cmp_d   [0:1];
reg  [7:0]  rtmp_q  [0:1];
reg  [7:0]  rtmp_d  [0:1];
reg  [7:0]  hold_q  [0:1];
reg  [7:0]  hold_d  [0:1];
reg  [7:0]  ctl0_q  [0:1];
reg  [7:0]  ctl0_d  [0:1];
reg  [7:0]  ctl1_q  [0:1];
reg  [7:0]  ctl1_d  [0:1];
reg  [2:0]  db_q    [0:1];
reg  [2:0]  db_d    [0:1];
reg  [1:0]  lvl_q;
reg  [1:0]  lvl_d;
reg  [1:0]  out_d;
reg  [1:0]  evt_d;
reg  [1:0]  cap_prev_q;
reg         cmp_prev_q;
reg  [7:0]  rd_byte;

wire [13:0] idx     = PADDR[15:2];
wire        hit     = (PADDR[1:0] == 2'h0) && (idx[13:4] == `TCP_IDX_PAGE);
wire        tsel    = idx[3];
wire [2:0]  sub     = idx[2:0];
wire        setup   = PSEL & ~PENABLE;
wire        rd_set  = setup & ~PWRITE & hit;
wire        wr_acc  = PSEL & PENABLE & PREADY & PWRITE & hit;
wire [7:0]  wd      = PWDATA[7:0];

integer     t;
// separate index for the clocked loops, so no variable has two writers
integer     u;

////////////////////////////////////////////////////////////////////////////////
// read mux, sampled in the setup cycle

always @* begin
    rd_byte = `TCP_RST_BYTE;
    case (sub)
        `TCP_SUB_CNT_HI: begin
            rd_byte = cnt_q[tsel][15:8];
        end
        `TCP_SUB_CNT_LO: begin
            if (ctl1_q[tsel][`TCP_C1_EN]) begin
                rd_byte = hold_q[tsel];
            end else begin
                rd_byte = cnt_q[tsel][7:0];
            end
        end
        `TCP_SUB_RLD_HI: begin
            rd_byte = rld_q[tsel][15:8];
        end
        `TCP_SUB_RLD_LO: begin
            rd_byte = rld_q[tsel][7:0];
        end
        `TCP_SUB_CMP_HI: begin
            rd_byte = cmp_q[tsel][15:8];
        end
        `TCP_SUB_CMP_LO: begin
            rd_byte = cmp_q[tsel][7:0];
        end
        `TCP_SUB_CTL0: begin
            rd_byte = ctl0_q[tsel];
        end
        `TCP_SUB_CTL1: begin
            rd_byte = ctl1_q[tsel];
        end
        default: begin
            rd_byte = `TCP_RST_BYTE;
        end
    endcase
end

////////////////////////////////////////////////////////////////////////////////
// per-timer next state

reg         en;
reg         pol;
reg  [3:0]  mode;
reg         tick;
reg         reach;
reg         capt;
reg         capm;
reg  [1:0]  cfg;

always @* begin
    en    = 1'b0;
    pol   = 1'b0;
    mode  = 4'h0;
    tick  = 1'b0;
    reach = 1'b0;
    capt  = 1'b0;
    capm  = 1'b0;
    cfg   = 2'h0;
    for (t = 0; t < 2; t = t + 1) begin
        cnt_d[t]  = cnt_q[t];
        rld_d[t]  = rld_q[t];
        cmp_d[t]  = cmp_q[t];
        rtmp_d[t] = rtmp_q[t];
        hold_d[t] = hold_q[t];
        ctl0_d[t] = ctl0_q[t];
        ctl1_d[t] = ctl1_q[t];
        db_d[t]   = db_q[t];
        lvl_d[t]  = lvl_q[t];
        evt_d[t]  = 1'b0;

        en   = ctl1_q[t][`TCP_C1_EN];
        pol  = ctl1_q[t][`TCP_C1_POL];
        mode = mode_of(ctl0_q[t], ctl1_q[t]);
        cfg  = ctl0_q[t][`TCP_C0_IRQ_HI:`TCP_C0_IRQ_LO];
        capm = (mode == `TCP_MODE_CAPT) || (mode == `TCP_MODE_CAPCMP);

        // comparator mode counts selected input edges, others every clock
        if (mode == `TCP_MODE_COMPCNT) begin
            tick = edge_of(CMP_IN, cmp_prev_q, pol);
        end else begin
            tick = 1'b1;
        end
        reach = en && tick && (cnt_q[t] == rld_q[t]);
        capt  = en && capm && edge_of(CAP_IN[t], cap_prev_q[t], pol);

        if (en && tick) begin
            if (reach) begin
                cnt_d[t] = `TCP_RST_CNT;
            end else begin
                cnt_d[t] = cnt_q[t] + 16'h0001;
            end
        end

        // event definition; a reload event clears capture status
        if (reach) begin
            ctl0_d[t][`TCP_C0_CAPST] = 1'b0;
            if (cfg != `TCP_IRQ_CAPT_ONLY) begin
                evt_d[t] = 1'b1;
            end
        end

        // output toggle on match, then deadband hold-off
        if (!en) begin
            lvl_d[t] = 1'b0;
        end else if (!capm && (cnt_q[t] == cmp_q[t])) begin
            lvl_d[t] = ~lvl_q[t];
            db_d[t]  = ctl0_q[t][`TCP_C0_DB_HI:`TCP_C0_DB_LO];
        end else if (db_q[t] != 3'h0) begin
            db_d[t] = db_q[t] - 3'h1;
        end
        if (db_q[t] == 3'h0) begin
            out_d[t] = lvl_q[t] ^ pol;
        end else begin
            out_d[t] = PWM_OUT[t];
        end

        // holder catches low byte at the same edge the high byte is sampled
        if (rd_set && (tsel == t) && (sub == `TCP_SUB_CNT_HI) && en) begin
            hold_d[t] = cnt_q[t][7:0];
        end

        // single-byte writes override counting in the same edge
        if (wr_acc && (tsel == t)) begin
            case (sub)
                `TCP_SUB_CNT_HI: begin
                    cnt_d[t][15:8] = wd;
                end
                `TCP_SUB_CNT_LO: begin
                    cnt_d[t][7:0] = wd;
                end
                `TCP_SUB_RLD_HI: begin
                    rtmp_d[t] = wd;
                end
                `TCP_SUB_RLD_LO: begin
                    rld_d[t] = {rtmp_q[t], wd};
                end
                `TCP_SUB_CMP_HI: begin
                    cmp_d[t][15:8] = wd;
                end
                `TCP_SUB_CMP_LO: begin
                    cmp_d[t][7:0] = wd;
                end
                `TCP_SUB_CTL0: begin
                    // status bit is hardware owned
                    ctl0_d[t][7:1] = wd[7:1];
                end
                `TCP_SUB_CTL1: begin
                    ctl1_d[t] = wd;
                end
                default: begin
                    ctl1_d[t] = ctl1_q[t];
                end
            endcase
        end

        // capture last so a same-cycle compare write cannot lose the count
        if (capt) begin
            cmp_d[t] = cnt_q[t];
            ctl0_d[t][`TCP_C0_CAPST] = 1'b1;
            if (cfg != `TCP_IRQ_RLD_ONLY) begin
                evt_d[t] = 1'b1;
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// state and bus outputs

always @(posedge SYS_CLK) begin
    if (!RST_N) begin
        for (u = 0; u < 2; u = u + 1) begin
            cnt_q[u]  <= `TCP_RST_CNT;
            rld_q[u]  <= `TCP_RST_WORD;
            cmp_q[u]  <= `TCP_RST_WORD;
            rtmp_q[u] <= `TCP_RST_BYTE;
            hold_q[u] <= `TCP_RST_BYTE;
            ctl0_q[u] <= `TCP_RST_BYTE;
            ctl1_q[u] <= `TCP_RST_BYTE;
            db_q[u]   <= 3'h0;
        end
        lvl_q      <= 2'h0;
        cap_prev_q <= 2'h0;
        cmp_prev_q <= 1'b0;
        PWM_OUT    <= 2'h0;
        TMR_EVT    <= 2'h0;
        PRDATA     <= 32'h0000_0000;
        PREADY     <= 1'b0;
        PSLVERR    <= 1'b0;
    end else begin
        for (u = 0; u < 2; u = u + 1) begin
            cnt_q[u]  <= cnt_d[u];
            rld_q[u]  <= rld_d[u];
            cmp_q[u]  <= cmp_d[u];
            rtmp_q[u] <= rtmp_d[u];
            hold_q[u] <= hold_d[u];
            ctl0_q[u] <= ctl0_d[u];
            ctl1_q[u] <= ctl1_d[u];
            db_q[u]   <= db_d[u];
        end
        lvl_q      <= lvl_d;
        cap_prev_q <= CAP_IN;
        cmp_prev_q <= CMP_IN;
        PWM_OUT    <= out_d;
        TMR_EVT    <= evt_d;
        // one access cycle per transfer; ready only in that cycle
        PREADY     <= setup;
        PSLVERR    <= setup & ~hit;
        if (rd_set) begin
            PRDATA <= {24'h00_0000, rd_byte};
        end else begin
            PRDATA <= 32'h0000_0000;
        end
    end
end

endmodule

// *** tcp_timer_regs_chk.sv ***
`timescale 1ns/1ns
module tcp_timer_regs_chk (
    input logic        SYS_CLK,
    input logic        RST_N,
    input logic        PSEL,
    input logic        PENABLE,
    input logic [15:0] PADDR,
    input logic [31:0] PRDATA,
    input logic        PREADY,
    input logic        PSLVERR,
    input logic [1:0]  PWM_OUT,
    input logic [1:0]  TMR_EVT
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    a_ready_after_setup: assert property (PSEL && !PENABLE |=> PREADY)
        else $error("no ready after setup");
    a_ready_in_access: assert property (PREADY |-> PSEL && PENABLE)
        else $error("ready outside access");
    a_ready_one_cycle: assert property (PREADY |=> !PREADY)
        else $error("ready held too long");
    a_err_with_ready: assert property (PSLVERR |-> PREADY)
        else $error("error without ready");
    a_data_idle_zero: assert property (!PREADY || PSLVERR |-> PRDATA == 32'h0)
        else $error("read data outside access");
    a_misaligned_err: assert property (PSEL && !PENABLE && PADDR[1:0] != 2'h0 |=> PSLVERR)
        else $error("misaligned not refused");
    a_mapped_no_err: assert property (PSEL && !PENABLE && PADDR[15:6] == 10'h0F0
        && PADDR[1:0] == 2'h0 |=> !PSLVERR)
        else $error("mapped access refused");
    a_event_pulse: assert property (TMR_EVT[0] |=> !TMR_EVT[0])
        else $error("event longer than one cycle");
    // reset check must stay live while reset is low
    a_reset_quiet: assert property (disable iff (1'b0)
        !RST_N |=> PWM_OUT == 2'h0 && TMR_EVT == 2'h0 && !PREADY)
        else $error("outputs active in reset");
endmodule
bind tcp_timer_regs tcp_timer_regs_chk u_chk (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
    .PSEL(PSEL), .PENABLE(PENABLE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .PWM_OUT(PWM_OUT), .TMR_EVT(TMR_EVT));

// *** tb_tcp_timer_regs.sv ***
`timescale 1ns/1ns
`include "tcp_consts.vh"
module tb_tcp_timer_regs;
    localparam logic [11:0] T0 = `TCP_IDX_T0_CNT_HI;
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h00000000;
    logic [1:0]  cap_in = 2'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [1:0]  pwm_out;
    logic [1:0]  tmr_evt;
    logic [31:0] rd;
    logic [31:0] rd2;
    logic        er;
    int          n_errors = 0;
    int          check_count = 0;
    int          cycles = 0;
    int          n;

    tcp_timer_regs DUT (.SYS_CLK(sys_clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .CAP_IN(cap_in), .CMP_IN(1'b0), .PWM_OUT(pwm_out), .TMR_EVT(tmr_evt));

    initial begin
        forever #25 sys_clk = ~sys_clk;
    end
////////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] ad(input logic [11:0] i);
        return {2'h0, i, 2'h0};
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // waits on pready, never on a fixed count
    task automatic apb(input logic w, input logic [15:0] a, input logic [7:0] d,
                       output logic [31:0] rv, output logic ev);
        int k;
        k = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        rv = prdata;
        ev = pslverr;
        if (k >= 16) n_errors++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        apb(1'b1, a, d, rd, er);
    endtask

    task automatic rdc(input string what, input logic [15:0] a, input logic [7:0] exp);
        apb(1'b0, a, 8'h00, rd, er);
        check(what, rd, {24'h000000, exp});
    endtask

    task automatic wait_evt(output int c);
        c = 0;
        do begin
            @(posedge sys_clk);
            c++;
        end while (tmr_evt[0] !== 1'b1 && c < 100);
    endtask
////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rdc("t0 cnt hi", ad(T0), 8'h00);
        rdc("t0 cnt lo", ad(`TCP_IDX_T0_CNT_LO), 8'h01);
        rdc("t1 cnt lo", ad(`TCP_IDX_T1_CNT_LO), 8'h01);
        rdc("t1 cmp lo", ad(`TCP_IDX_T1_CMP_LO), 8'h00);
    endtask

    task automatic t_reload;
        wr(ad(T0 + `TCP_SUB_RLD_HI), 8'h12);
        rdc("rld hi held", ad(T0 + `TCP_SUB_RLD_HI), 8'h00);
        wr(ad(T0 + `TCP_SUB_RLD_LO), 8'h05);
        rdc("rld hi", ad(T0 + `TCP_SUB_RLD_HI), 8'h12);
        rdc("rld lo", ad(T0 + `TCP_SUB_RLD_LO), 8'h05);
        wr(ad(T0 + `TCP_SUB_RLD_HI), 8'h00);
        wr(ad(T0 + `TCP_SUB_RLD_LO), 8'h05);
    endtask

    // short reload so the live low byte surely moves between the two reads
    task automatic t_run;
        wr(ad(T0 + `TCP_SUB_CTL1), 8'h81);
        wait_evt(n);
        wait_evt(n);
        check("reload period", n, 5);
        rdc("cnt hi run", ad(T0), 8'h00);
        apb(1'b0, ad(T0 + `TCP_SUB_CNT_LO), 8'h00, rd, er);
        apb(1'b0, ad(T0 + `TCP_SUB_CNT_LO), 8'h00, rd2, er);
        check("held lo", rd2, rd);
        wr(ad(T0 + `TCP_SUB_CTL1), 8'h00);
    endtask

    task automatic t_count_write;
        wr(ad(T0 + `TCP_SUB_CNT_LO), 8'h55);
        rdc("lo direct", ad(T0 + `TCP_SUB_CNT_LO), 8'h55);
        wr(ad(T0 + `TCP_SUB_RLD_HI), 8'h02);
        wr(ad(T0 + `TCP_SUB_RLD_LO), 8'h00);
        wr(ad(T0 + `TCP_SUB_CTL1), 8'h81);
        wr(ad(T0), 8'h01);
        wr(ad(T0 + `TCP_SUB_CTL1), 8'h00);
        rdc("hi written", ad(T0), 8'h01);
    endtask

    task automatic t_control;
        wr(ad(`TCP_IDX_T0_CTL0), 8'hFF);
        rdc("t0 ctl0", ad(`TCP_IDX_T0_CTL0), 8'hFE);
        rdc("t1 ctl0", ad(`TCP_IDX_T1_CTL0), 8'h00);
        rdc("t1 cnt hi", ad(`TCP_IDX_T1_CNT_HI), 8'h00);
        check("t1 quiet", {30'h0, pwm_out[1], tmr_evt[1]}, 32'h0);
    endtask

    // count loaded only while stopped, since byte writes are not coherent
    task automatic t_pwm;
        wr(ad(`TCP_IDX_T0_CTL0), 8'h00);
        wr(ad(T0), 8'h00);
        wr(ad(T0 + `TCP_SUB_CNT_LO), 8'h01);
        wr(ad(T0 + `TCP_SUB_RLD_HI), 8'h00);
        wr(ad(T0 + `TCP_SUB_RLD_LO), 8'h10);
        wr(ad(T0 + `TCP_SUB_CMP_HI), 8'h00);
        wr(ad(T0 + `TCP_SUB_CMP_LO), 8'h04);
        wr(ad(T0 + `TCP_SUB_CTL1), 8'h40);
        repeat (2) @(posedge sys_clk);
        check("idle level", {31'h0, pwm_out[0]}, 32'h1);
        wr(ad(T0 + `TCP_SUB_CTL1), 8'hC1);
        n = 0;
        while (pwm_out[0] !== 1'b0 && n < 40) begin
            @(posedge sys_clk);
            n++;
        end
        check("match toggle", {31'h0, pwm_out[0]}, 32'h0);
        wr(ad(T0 + `TCP_SUB_CTL1), 8'h00);
    endtask

    task automatic t_capture;
        wr(ad(T0), 8'h03);
        wr(ad(T0 + `TCP_SUB_CNT_LO), 8'h00);
        wr(ad(T0 + `TCP_SUB_RLD_HI), 8'h05);
        wr(ad(T0 + `TCP_SUB_RLD_LO), 8'h00);
        wr(ad(T0 + `TCP_SUB_CTL1), 8'h84);
        @(posedge sys_clk);
        cap_in <= 2'h1;
        wait_evt(n);
        check("capture event", n, 2);
        cap_in <= 2'h0;
        rdc("capture status", ad(`TCP_IDX_T0_CTL0), 8'h01);
        rdc("captured hi", ad(T0 + `TCP_SUB_CMP_HI), 8'h03);
        wr(ad(T0 + `TCP_SUB_CTL1), 8'h00);
    endtask

    task automatic t_unmapped;
        apb(1'b0, 16'h0000, 8'h00, rd, er);
        check("unmapped err", {31'h0, er}, 32'h1);
        check("unmapped data", rd, 32'h0);
        apb(1'b1, 16'h3C01, 8'hAA, rd, er);
        check("misaligned err", {31'h0, er}, 32'h1);
        rdc("cnt hi kept", ad(T0), 8'h01);
    endtask
////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        t_reset;
        t_reload;
        t_run;
        t_count_write;
        t_control;
        t_unmapped;
        t_pwm;
        t_capture;
        report_and_stop;
    end

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            report_and_stop;
        end
    end
endmodule
